/* hw/flss_map.svh */
// Constants for the fuse, lock and signature store.
//
// Functional notes
// RL1 - Boot mode 1: no boot section restrictions.
// RL2 - Boot mode 2: store instruction cannot write boot.
// RL3 - Boot mode 3: block boot writes, application-issued boot reads.
// RL4 - Boot mode 4: block only application-issued boot reads.
// RL5 - Modes 3/4, application vectors: mask interrupts in boot.
// RL6 - Bits read one unprogrammed, zero programmed.
// RL7 - Upper fuse byte layout and defaults.
// RL8 - Lower fuse byte layout and defaults.
// RL9 - Serial programming cannot alter its enable fuse.
// RL10 - Debug fuse keeps clocks running in sleep.
// RL11 - Default boot size selects largest boot section.
// RL12 - Defaults: longest start-up, internal 1MHz RC.
// RL13 - Chip erase leaves fuses unchanged.
// RL14 - Memory lock bit one programmed freezes fuses.
// RL15 - Host programs fuses before lock bits.
// RL16 - Fuses latch on programming entry, apply after exit; the code applies changes only at the next entry.
// RL17 - EEPROM preserve fuse acts at once.
// RL18 - Fuses also latch at power-up, normal mode.
// RL19 - Three signature bytes readable, even when locked.
// RL20 - Four calibration bytes for 1, 2, 4, 8 MHz.
// RL21 - Reset loads 1MHz calibration into trim register.
// RL22 - Flash: 128 pages of 64 words.
// RL23 - EEPROM: 128 pages of 4 bytes.
// RL24 - Lock bits return to one only by erase.
// RL25 - Application lower lock bit blocks application writes.
// RL26 - Latched fuses stay stable between latch events.
`ifndef FLSS_MAP_SVH
`define FLSS_MAP_SVH

// ----------------------------------------------------------------
// Fuse defaults and positions
// ----------------------------------------------------------------
`define FLSS_FUSE_HI_DEFAULT 8'h99
`define FLSS_FUSE_LO_DEFAULT 8'he1
`define FLSS_HI_SERIAL_PROGRAM_ENABLE_FUSE_BIT    5
`define FLSS_HI_EEPROM_PRESERVE_FUSE_BIT   3

// ----------------------------------------------------------------
// Lock byte positions and default
// ----------------------------------------------------------------
`define FLSS_LOCK_DEFAULT    8'hff
`define FLSS_LOCK_BOOT_UP    5
`define FLSS_LOCK_BOOT_LO    4
`define FLSS_LOCK_APP_UP     3
`define FLSS_LOCK_APP_LO     2
`define FLSS_LOCK_MEM_ONE    0

// ----------------------------------------------------------------
// Signature row addresses
// ----------------------------------------------------------------
`define FLSS_SIG_ADDR_0      2'h0
`define FLSS_SIG_ADDR_1      2'h1
`define FLSS_SIG_ADDR_2      2'h2

// ----------------------------------------------------------------
// Memory geometry
// ----------------------------------------------------------------
`define FLSS_FLASH_WORDS     14'h2000
`define FLSS_BOOT_MIN_WORDS  14'h0080
`define FLSS_PC_TOP_BIT      12
`define FLSS_PAGE_WORD_BITS  6
`define FLSS_EE_TOP_BIT      8
`define FLSS_EE_BYTE_BITS    2

`endif

/* hw/flss_pkg.sv */
// Types shared by the fuse, lock and signature store.
package flss_pkg;

  // Upper fuse byte, bit 7 first.
  typedef struct packed {
    logic debug_enable_fuse;
    logic boundary_port_enable_fuse;
    logic serial_program_enable_fuse;
    logic oscillator_option_fuse;
    logic eeprom_preserve_fuse;
    logic boot_size_upper;
    logic boot_size_lower;
    logic reset_vector_select;
  } flss_fuse_hi_t;

  // Lower fuse byte, bit 7 first.
  typedef struct packed {
    logic brownout_level_fuse;
    logic brownout_enable_fuse;
    logic startup_time_upper;
    logic startup_time_lower;
    logic clock_source_bit3;
    logic clock_source_bit2;
    logic clock_source_bit1;
    logic clock_source_bit0;
  } flss_fuse_lo_t;

  // Programming interface operations.
  typedef enum logic [3:0] {
    FLSS_OP_WR_FUSE_LO,
    FLSS_OP_WR_FUSE_HI,
    FLSS_OP_WR_LOCK,
    FLSS_OP_CHIP_ERASE,
    FLSS_OP_RD_SIG,
    FLSS_OP_RD_CAL,
    FLSS_OP_RD_FUSE_LO,
    FLSS_OP_RD_FUSE_HI,
    FLSS_OP_RD_LOCK
  } flss_op_t;

  // One programming request.
  typedef struct packed {
    flss_op_t   op;
    logic [7:0] data;
    logic [1:0] addr;
  } flss_cmd_t;

endpackage

/* hw/flss_store.sv */
// Fuse, lock, signature and calibration store with section protection.
`timescale 1ns/10ps
`default_nettype none
`include "flss_map.svh"

module flss_store
  import flss_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE_0 = 8'h5a,  // Arbitrary value.
  parameter logic [7:0] SIG_BYTE_1 = 8'ha5,  // Arbitrary value.
  parameter logic [7:0] SIG_BYTE_2 = 8'h3c,  // Arbitrary value.
  parameter logic [7:0] CAL_1MHZ   = 8'h80,
  parameter logic [7:0] CAL_2MHZ   = 8'h81,
  parameter logic [7:0] CAL_4MHZ   = 8'h82,
  parameter logic [7:0] CAL_8MHZ   = 8'h83
) (
  // Clock, reset and enable.
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  // Programming interface.
  input  wire logic          prog_mode_i,
  input  wire logic          serial_mode_i,
  input  wire logic          cmd_valid_i,
  input  wire flss_cmd_t     cmd_i,
  output logic               rd_valid_o,
  output logic [7:0]         rd_data_o,
  output logic               chip_erase_o,
  output logic               eeprom_erase_o,
  // Processor core.
  input  wire logic [12:0]   exec_addr_i,
  input  wire logic [12:0]   target_addr_i,
  input  wire logic          spm_req_i,
  input  wire logic          lpm_req_i,
  input  wire logic          vectors_in_boot_i,
  output logic               spm_allow_o,
  output logic               lpm_allow_o,
  output logic               irq_block_o,
  input  wire logic          trim_we_i,
  input  wire logic [7:0]    trim_wdata_i,
  output logic [7:0]         oscillator_trim_register_o,
  // Geometry decode.
  input  wire logic [8:0]    eeprom_byte_address_i,
  output logic [6:0]         page_select_index_o,
  output logic [5:0]         page_word_index_o,
  output logic [6:0]         ee_page_index_o,
  output logic [1:0]         ee_byte_index_o,
  // Latched configuration.
  output flss_fuse_hi_t      fuse_hi_o,
  output flss_fuse_lo_t      fuse_lo_o,
  output logic               eeprom_preserve_o,
  output logic               clk_keep_sleep_o
);

  // ----------------------------------------------------------------
  // Stored and latched configuration
  // ----------------------------------------------------------------
  logic [7:0]    fuse_hi_ff;
  logic [7:0]    fuse_lo_ff;
  logic [7:0]    lock_ff;
  flss_fuse_hi_t lat_hi_ff;
  flss_fuse_lo_t lat_lo_ff;
  logic          prog_prev_ff;
  logic          pwrup_ff;
  logic [7:0]    nxt_fuse_hi;
  logic [7:0]    nxt_fuse_lo;
  logic [7:0]    nxt_lock;
  flss_fuse_hi_t nxt_lat_hi;
  flss_fuse_lo_t nxt_lat_lo;
  logic          nxt_prog_prev;
  logic          nxt_pwrup;
  logic          prog_entry;
  logic          fuse_wr_ok;
  logic          cmd_take;

  // Requests are only taken in programming mode.
  assign cmd_take   = cmd_valid_i && prog_mode_i;
  assign prog_entry = prog_mode_i && !prog_prev_ff;
  assign fuse_wr_ok = lock_ff[`FLSS_LOCK_MEM_ONE];  // RL14

  // Next values of the non-volatile bytes and their latched copies.
  always_comb begin
    nxt_fuse_hi   = fuse_hi_ff;
    nxt_fuse_lo   = fuse_lo_ff;
    nxt_lock      = lock_ff;
    nxt_lat_hi    = lat_hi_ff;
    nxt_lat_lo    = lat_lo_ff;
    nxt_prog_prev = prog_mode_i;
    nxt_pwrup     = 1'b0;
    if (cmd_take) begin
      unique case (cmd_i.op)
        FLSS_OP_WR_FUSE_LO: begin
          if (fuse_wr_ok) begin  // RL14
            nxt_fuse_lo = cmd_i.data;
          end
        end
        FLSS_OP_WR_FUSE_HI: begin
          if (fuse_wr_ok) begin  // RL14
            nxt_fuse_hi = cmd_i.data;
            if (serial_mode_i) begin
              // The serial interface keeps its own enable untouched.
              nxt_fuse_hi[`FLSS_HI_SERIAL_PROGRAM_ENABLE_FUSE_BIT] = fuse_hi_ff[`FLSS_HI_SERIAL_PROGRAM_ENABLE_FUSE_BIT];  // RL9
            end
          end
        end
        FLSS_OP_WR_LOCK: begin
          // Writes can only program bits, never release them.
          nxt_lock = lock_ff & cmd_i.data;  // RL24
        end
        FLSS_OP_CHIP_ERASE: begin
          // Erase releases every lock bit and leaves the fuses alone.
          nxt_lock = `FLSS_LOCK_DEFAULT;  // RL24 RL13
        end
        default: begin
        end
      endcase
    end
    // Latch on entry to programming mode, or once at power-up in normal mode.
    if (prog_entry || (pwrup_ff && !prog_mode_i)) begin  // RL16 RL18
      nxt_lat_hi = flss_fuse_hi_t'(fuse_hi_ff);
      nxt_lat_lo = flss_fuse_lo_t'(fuse_lo_ff);
    end
  end

  // Registers for the stored and latched bytes; defaults after reset.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fuse_hi_ff   <= `FLSS_FUSE_HI_DEFAULT;  // RL7 RL11
      fuse_lo_ff   <= `FLSS_FUSE_LO_DEFAULT;  // RL8 RL12
      lock_ff      <= `FLSS_LOCK_DEFAULT;
      lat_hi_ff    <= flss_fuse_hi_t'(`FLSS_FUSE_HI_DEFAULT);
      lat_lo_ff    <= flss_fuse_lo_t'(`FLSS_FUSE_LO_DEFAULT);
      prog_prev_ff <= 1'b0;
      pwrup_ff     <= 1'b1;
    end else if (ce_i) begin
      fuse_hi_ff   <= nxt_fuse_hi;
      fuse_lo_ff   <= nxt_fuse_lo;
      lock_ff      <= nxt_lock;
      lat_hi_ff    <= nxt_lat_hi;  // RL26
      lat_lo_ff    <= nxt_lat_lo;
      prog_prev_ff <= nxt_prog_prev;
      pwrup_ff     <= nxt_pwrup;
    end
  end

  // Latched fuses go out unchanged between latch events.
  assign fuse_hi_o = lat_hi_ff;  // RL26
  assign fuse_lo_o = lat_lo_ff;
  // The preserve fuse counts as soon as it is programmed in the store.
  assign eeprom_preserve_o = !(lat_hi_ff.eeprom_preserve_fuse &&
                               fuse_hi_ff[`FLSS_HI_EEPROM_PRESERVE_FUSE_BIT]);  // RL17 RL6
  // A programmed debug fuse reads zero and keeps sleep clocks alive.
  assign clk_keep_sleep_o = !lat_hi_ff.debug_enable_fuse;  // RL10 RL6

  // ----------------------------------------------------------------
  // Read answers and erase strobes
  // ----------------------------------------------------------------
  logic       rd_valid_ff;
  logic [7:0] rd_data_ff;
  logic       erase_ff;
  logic       ee_erase_ff;
  logic       nxt_rd_valid;
  logic [7:0] nxt_rd_data;
  logic       nxt_erase;
  logic       nxt_ee_erase;

  // Read data selection; signature reads ignore the lock state.
  always_comb begin
    nxt_rd_valid = 1'b0;
    nxt_rd_data  = rd_data_ff;
    nxt_erase    = 1'b0;
    nxt_ee_erase = 1'b0;
    if (cmd_take) begin
      unique case (cmd_i.op)
        FLSS_OP_RD_SIG: begin
          nxt_rd_valid = 1'b1;
          unique case (cmd_i.addr)  // RL19
            `FLSS_SIG_ADDR_0: nxt_rd_data = SIG_BYTE_0;
            `FLSS_SIG_ADDR_1: nxt_rd_data = SIG_BYTE_1;
            `FLSS_SIG_ADDR_2: nxt_rd_data = SIG_BYTE_2;
            default:          nxt_rd_data = 8'h00;
          endcase
        end
        FLSS_OP_RD_CAL: begin
          nxt_rd_valid = 1'b1;
          unique case (cmd_i.addr)  // RL20
            2'h0:    nxt_rd_data = CAL_1MHZ;
            2'h1:    nxt_rd_data = CAL_2MHZ;
            2'h2:    nxt_rd_data = CAL_4MHZ;
            default: nxt_rd_data = CAL_8MHZ;
          endcase
        end
        FLSS_OP_RD_FUSE_LO: begin
          nxt_rd_valid = 1'b1;
          nxt_rd_data  = fuse_lo_ff;  // RL6
        end
        FLSS_OP_RD_FUSE_HI: begin
          nxt_rd_valid = 1'b1;
          nxt_rd_data  = fuse_hi_ff;
        end
        FLSS_OP_RD_LOCK: begin
          nxt_rd_valid = 1'b1;
          nxt_rd_data  = lock_ff;
        end
        FLSS_OP_CHIP_ERASE: begin
          nxt_erase    = 1'b1;
          nxt_ee_erase = !eeprom_preserve_o;  // RL17
        end
        default: begin
        end
      endcase
    end
  end

  // Registers for read answers and strobes.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= 8'h00;
      erase_ff    <= 1'b0;
      ee_erase_ff <= 1'b0;
    end else if (ce_i) begin
      rd_valid_ff <= nxt_rd_valid;
      rd_data_ff  <= nxt_rd_data;
      erase_ff    <= nxt_erase;
      ee_erase_ff <= nxt_ee_erase;
    end
  end

  assign rd_valid_o     = rd_valid_ff;
  assign rd_data_o      = rd_data_ff;
  assign chip_erase_o   = erase_ff;
  assign eeprom_erase_o = ee_erase_ff;

  // ----------------------------------------------------------------
  // Oscillator trim register
  // ----------------------------------------------------------------
  logic [7:0] trim_ff;
  logic [7:0] nxt_trim;

  // Software loads the other frequencies' values itself.
  always_comb begin
    nxt_trim = trim_ff;
    if (trim_we_i) begin
      nxt_trim = trim_wdata_i;
    end
  end

  // Reset places the 1MHz value.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trim_ff <= CAL_1MHZ;  // RL21
    end else if (ce_i) begin
      trim_ff <= nxt_trim;
    end
  end

  assign oscillator_trim_register_o = trim_ff;

  // ----------------------------------------------------------------
  // Section protection and geometry
  // ----------------------------------------------------------------
  logic [13:0] boot_words;
  logic [13:0] boot_start;
  logic        tgt_in_boot;
  logic        exe_in_boot;
  logic [1:0]  boot_mode;
  logic [1:0]  app_mode;

  // Boot size from the latched fuses; both bits programmed gives the largest.
  assign boot_words  = `FLSS_BOOT_MIN_WORDS <<
                       (~{lat_hi_ff.boot_size_upper, lat_hi_ff.boot_size_lower});  // RL11
  assign boot_start  = `FLSS_FLASH_WORDS - boot_words;
  assign tgt_in_boot = {1'b0, target_addr_i} >= boot_start;
  assign exe_in_boot = {1'b0, exec_addr_i} >= boot_start;
  assign boot_mode   = {lock_ff[`FLSS_LOCK_BOOT_UP], lock_ff[`FLSS_LOCK_BOOT_LO]};
  assign app_mode    = {lock_ff[`FLSS_LOCK_APP_UP], lock_ff[`FLSS_LOCK_APP_LO]};

  // Store instruction permission per section.
  always_comb begin
    spm_allow_o = 1'b1;  // RL1
    if (tgt_in_boot && !boot_mode[0]) begin
      spm_allow_o = 1'b0;  // RL2 RL3
    end
    if (!tgt_in_boot && !app_mode[0]) begin
      spm_allow_o = 1'b0;  // RL25
    end
  end

  // Load instruction permission; cross-section reads are checked only.
  always_comb begin
    lpm_allow_o = 1'b1;  // RL1
    if (tgt_in_boot && !exe_in_boot && !boot_mode[1]) begin
      lpm_allow_o = 1'b0;  // RL3 RL4
    end
    if (!tgt_in_boot && exe_in_boot && !app_mode[1]) begin
      lpm_allow_o = 1'b0;
    end
  end

  // Interrupt masking while running in the protected section.
  assign irq_block_o = (!boot_mode[1] && !vectors_in_boot_i && exe_in_boot) ||
                       (!app_mode[1] && vectors_in_boot_i && !exe_in_boot);  // RL5

  // Page split of flash and EEPROM addresses.
  assign page_select_index_o = target_addr_i[`FLSS_PC_TOP_BIT:`FLSS_PAGE_WORD_BITS];  // RL22
  assign page_word_index_o   = target_addr_i[`FLSS_PAGE_WORD_BITS-1:0];
  assign ee_page_index_o     = eeprom_byte_address_i[`FLSS_EE_TOP_BIT:`FLSS_EE_BYTE_BITS];  // RL23
  assign ee_byte_index_o     = eeprom_byte_address_i[`FLSS_EE_BYTE_BITS-1:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_entry;
    ce_i && prog_entry;
  endsequence

  sequence s_locked_fuse_wr;
    ce_i && cmd_take && !fuse_wr_ok &&
      (cmd_i.op == FLSS_OP_WR_FUSE_LO || cmd_i.op == FLSS_OP_WR_FUSE_HI);
  endsequence

  a_latch_on_entry: assert property ( // RL16
    s_entry |=> (lat_hi_ff == $past(fuse_hi_ff)) && (lat_lo_ff == $past(fuse_lo_ff)))
    else $error("Fuses not latched at programming entry.");

  a_latch_hold: assert property ( // RL26
    (prog_mode_i && prog_prev_ff && !pwrup_ff) |=> $stable(lat_hi_ff) && $stable(lat_lo_ff))
    else $error("Latched fuses changed inside programming mode.");

  a_fuse_locked: assert property ( // RL14
    s_locked_fuse_wr |=> $stable(fuse_hi_ff) && $stable(fuse_lo_ff))
    else $error("Fuse changed while memory lock bit one programmed.");

  a_lock_one_way: assert property ( // RL24
    !(ce_i && cmd_take && cmd_i.op == FLSS_OP_CHIP_ERASE) |=>
      ((lock_ff & ~$past(lock_ff)) == 8'h00))
    else $error("Lock bit released without chip erase.");

  a_erase_keeps: assert property ( // RL13
    (ce_i && cmd_take && cmd_i.op == FLSS_OP_CHIP_ERASE) |=>
      $stable(fuse_hi_ff) && $stable(fuse_lo_ff) && lock_ff == `FLSS_LOCK_DEFAULT
      && chip_erase_o)
    else $error("Chip erase handled wrongly.");

  a_serial_program_enable_fuse_kept: assert property ( // RL9
    (ce_i && cmd_take && serial_mode_i && cmd_i.op == FLSS_OP_WR_FUSE_HI) |=>
      $stable(fuse_hi_ff[`FLSS_HI_SERIAL_PROGRAM_ENABLE_FUSE_BIT]))
    else $error("Serial programming altered its enable fuse.");

  a_sig_read: assert property ( // RL19
    (ce_i && cmd_take && cmd_i.op == FLSS_OP_RD_SIG && cmd_i.addr == `FLSS_SIG_ADDR_1)
      |=> rd_valid_o && rd_data_o == SIG_BYTE_1)
    else $error("Signature read returned wrong byte.");

  a_boot_write: assert property ( // RL2
    (tgt_in_boot && boot_mode == 2'b10) |-> !spm_allow_o && lpm_allow_o)
    else $error("Boot mode two permissions wrong.");

  a_boot_read: assert property ( // RL4
    (tgt_in_boot && !exe_in_boot && boot_mode == 2'b01 && app_mode == 2'b11)
      |-> spm_allow_o && !lpm_allow_o)
    else $error("Boot mode four permissions wrong.");

  a_eeprom_preserve_fuse_now: assert property ( // RL17
    (ce_i && cmd_take && fuse_wr_ok && cmd_i.op == FLSS_OP_WR_FUSE_HI &&
     !serial_mode_i && !cmd_i.data[`FLSS_HI_EEPROM_PRESERVE_FUSE_BIT]) |=> eeprom_preserve_o)
    else $error("Preserve fuse did not act at once.");

endmodule
`default_nettype wire

/* test/flss_host_model.sv */
// Programming host model that issues requests to the store.
`timescale 1ns/10ps
`default_nettype none

module flss_host_model
  import flss_pkg::*;
(
  // Clock.
  input  wire logic clk_i,
  // Request port.
  output var logic  cmd_valid_o,
  output flss_cmd_t cmd_o
);
  // The bus starts idle.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end

  // One request, held for one whole clock, then the bus is scrambled.
  task automatic send(input flss_op_t op, input logic [7:0] data,
                      input logic [1:0] addr);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_o = '{op: op, data: data, addr: addr};
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_o = ~cmd_o;  // An idle bus must not keep showing the old request.
  endtask
endmodule

`default_nettype wire

/* test/fuse_lock_signature_store_tb.sv */
// Self-checking testbench for the fuse, lock and signature store.
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

module fuse_lock_signature_store_tb
  import flss_pkg::*;
;
  typedef struct packed {
    flss_op_t   op;
    logic [1:0] addr;
    logic [7:0] exp;
  } flss_row_t;

  logic clk_i, rst_n_i, ce_i, prog_mode_i, serial_mode_i, cmd_valid;
  flss_cmd_t cmd;
  logic [12:0] exec_addr, target_addr;
  logic vib, trim_we, rd_valid_o, chip_erase_o, eeprom_erase_o;
  logic spm_allow_o, lpm_allow_o, irq_block_o, eeprom_preserve_o, clk_keep_sleep_o;
  logic [7:0] trim_wdata, rd_data_o, trim_o;
  logic [8:0] ee_addr;
  logic [6:0] page_o, ee_page_o;
  logic [5:0] word_o;
  logic [1:0] ee_byte_o;
  flss_fuse_hi_t fuse_hi_o;
  flss_fuse_lo_t fuse_lo_o;
  flss_row_t rows [11];
  int mismatches = 0;
  int checked = 0;

  // ----------------------------------------------------------------
  // Design and host
  // ----------------------------------------------------------------
  flss_store dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .prog_mode_i(prog_mode_i),
    .serial_mode_i(serial_mode_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .chip_erase_o(chip_erase_o),
    .eeprom_erase_o(eeprom_erase_o), .exec_addr_i(exec_addr),
    .target_addr_i(target_addr), .spm_req_i(1'b1), .lpm_req_i(1'b1),
    .vectors_in_boot_i(vib), .spm_allow_o(spm_allow_o), .lpm_allow_o(lpm_allow_o),
    .irq_block_o(irq_block_o), .trim_we_i(trim_we), .trim_wdata_i(trim_wdata),
    .oscillator_trim_register_o(trim_o), .eeprom_byte_address_i(ee_addr),
    .page_select_index_o(page_o), .page_word_index_o(word_o),
    .ee_page_index_o(ee_page_o), .ee_byte_index_o(ee_byte_o),
    .fuse_hi_o(fuse_hi_o), .fuse_lo_o(fuse_lo_o),
    .eeprom_preserve_o(eeprom_preserve_o), .clk_keep_sleep_o(clk_keep_sleep_o)
  );

  flss_host_model host_u (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd));

  // Clock of 40 ns period.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Issues a read and compares the answer in the cycle it stands.
  task automatic rd(input flss_op_t op, input logic [1:0] a, input logic [7:0] ex);
    host_u.send(op, 8'h00, a);
    `CHK("rd_valid", 1'b1, rd_valid_o)
    `CHK("rd_data", ex, rd_data_o)
  endtask

  // Applies core addresses and compares spm, lpm and irq block.
  task automatic core(input logic [12:0] ex, input logic [12:0] tg, input logic vb,
                      input logic [2:0] exp);
    @(negedge clk_i);
    exec_addr = ex;
    target_addr = tg;
    vib = vb;
    #5;
    `CHK("core_allow", exp, {spm_allow_o, lpm_allow_o, irq_block_o})
  endtask

  // Changes programming mode and lets the latched copy settle.
  task automatic set_prog(input logic v);
    @(negedge clk_i);
    prog_mode_i = v;
    repeat (2) @(negedge clk_i);
  endtask

  // Watchdog far beyond the length of the sequence.
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    prog_mode_i = 1'b0;
    serial_mode_i = 1'b0;
    exec_addr = 13'h0000;
    target_addr = 13'h1abc;
    vib = 1'b0;
    trim_we = 1'b0;
    trim_wdata = 8'h00;
    ee_addr = 9'h1a7;
    rows[0]  = '{FLSS_OP_RD_SIG, 2'h0, 8'h5a};
    rows[1]  = '{FLSS_OP_RD_SIG, 2'h1, 8'ha5};
    rows[2]  = '{FLSS_OP_RD_SIG, 2'h2, 8'h3c};
    rows[3]  = '{FLSS_OP_RD_SIG, 2'h3, 8'h00};
    rows[4]  = '{FLSS_OP_RD_CAL, 2'h0, 8'h80};
    rows[5]  = '{FLSS_OP_RD_CAL, 2'h1, 8'h81};
    rows[6]  = '{FLSS_OP_RD_CAL, 2'h2, 8'h82};
    rows[7]  = '{FLSS_OP_RD_CAL, 2'h3, 8'h83};
    rows[8]  = '{FLSS_OP_RD_FUSE_LO, 2'h0, 8'he1};
    rows[9]  = '{FLSS_OP_RD_FUSE_HI, 2'h0, 8'h99};
    rows[10] = '{FLSS_OP_RD_LOCK, 2'h0, 8'hff};
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    `CHK("fuse_hi", 8'h99, fuse_hi_o)
    `CHK("fuse_lo", 8'he1, fuse_lo_o)
    `CHK("clock_src", 6'h21, fuse_lo_o[5:0])
    `CHK("trim", 8'h80, trim_o)
    `CHK("keep_sleep", 1'b0, clk_keep_sleep_o)
    `CHK("preserve", 1'b0, eeprom_preserve_o)
    `CHK("flash_idx", 13'h1abc, {page_o, word_o})
    `CHK("ee_idx", 9'h1a7, {ee_page_o, ee_byte_o})
    core(13'h0100, 13'h1c00, 1'b0, 3'b110);
    // Software load of the trim register.
    @(negedge clk_i);
    trim_we = 1'b1;
    trim_wdata = 8'h3f;
    @(negedge clk_i);
    trim_we = 1'b0;
    `CHK("trim_sw", 8'h3f, trim_o)
    set_prog(1'b1);
    for (int i = 0; i < 11; i++) begin
      rd(rows[i].op, rows[i].addr, rows[i].exp);
    end
    // Fuse writes do not reach the latched copy in programming mode.
    host_u.send(FLSS_OP_WR_FUSE_LO, 8'hd4, 2'h0);
    host_u.send(FLSS_OP_WR_FUSE_HI, 8'h11, 2'h0);
    `CHK("preserve_now", 1'b1, eeprom_preserve_o)
    `CHK("fuse_lo_held", 8'he1, fuse_lo_o)
    `CHK("fuse_hi_held", 8'h99, fuse_hi_o)
    rd(FLSS_OP_RD_FUSE_LO, 2'h0, 8'hd4);
    serial_mode_i = 1'b1;
    host_u.send(FLSS_OP_WR_FUSE_HI, 8'h31, 2'h0);
    serial_mode_i = 1'b0;
    rd(FLSS_OP_RD_FUSE_HI, 2'h0, 8'h11);
    set_prog(1'b0);
    `CHK("fuse_lo_exit", 8'he1, fuse_lo_o)
    set_prog(1'b1);
    `CHK("fuse_lo_new", 8'hd4, fuse_lo_o)
    `CHK("fuse_hi_new", 8'h11, fuse_hi_o)
    `CHK("keep_sleep_on", 1'b1, clk_keep_sleep_o)
    // Lock bits only after the fuses are final.
    host_u.send(FLSS_OP_WR_LOCK, 8'hef, 2'h0);
    core(13'h0100, 13'h1c00, 1'b0, 3'b010);
    core(13'h0100, 13'h1bff, 1'b0, 3'b110);
    host_u.send(FLSS_OP_WR_LOCK, 8'hcf, 2'h0);
    core(13'h0100, 13'h1c00, 1'b0, 3'b000);
    core(13'h1c00, 13'h1c00, 1'b0, 3'b011);
    core(13'h1c00, 13'h1c00, 1'b1, 3'b010);
    host_u.send(FLSS_OP_WR_LOCK, 8'hff, 2'h0);
    rd(FLSS_OP_RD_LOCK, 2'h0, 8'hcf);
    host_u.send(FLSS_OP_CHIP_ERASE, 8'h00, 2'h0);
    `CHK("erase", 1'b1, chip_erase_o)
    `CHK("ee_erase", 1'b0, eeprom_erase_o)
    rd(FLSS_OP_RD_LOCK, 2'h0, 8'hff);
    rd(FLSS_OP_RD_FUSE_LO, 2'h0, 8'hd4);
    host_u.send(FLSS_OP_WR_LOCK, 8'hdf, 2'h0);
    core(13'h0100, 13'h1c00, 1'b0, 3'b100);
    core(13'h1c00, 13'h0100, 1'b0, 3'b111);
    host_u.send(FLSS_OP_WR_LOCK, 8'hdb, 2'h0);
    core(13'h0100, 13'h0100, 1'b0, 3'b010);
    host_u.send(FLSS_OP_WR_LOCK, 8'hda, 2'h0);
    host_u.send(FLSS_OP_WR_FUSE_LO, 8'h00, 2'h0);
    rd(FLSS_OP_RD_FUSE_LO, 2'h0, 8'hd4);
    rd(FLSS_OP_RD_SIG, 2'h0, 8'h5a);
    // A second reset in mid-run reloads trim and relatches.
    set_prog(1'b0);
    rst_n_i = 1'b0;
    @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    `CHK("trim_rst", 8'h80, trim_o)
    `CHK("fuse_lo_pwr", 8'he1, fuse_lo_o)
    // With the preserve fuse back at its default, erase also clears the EEPROM.
    set_prog(1'b1);
    host_u.send(FLSS_OP_CHIP_ERASE, 8'h00, 2'h0);
    `CHK("ee_erase_on", 1'b1, eeprom_erase_o)
    wrap_up();
  end
endmodule

`default_nettype wire
